// ===== hdl/wtx_pkg.sv
// shared constants for the transmit sequencing and beacon element block
package wtx_pkg;
  localparam int         SEQ_W       = 11;
  localparam int         NFLOW       = 8;
  localparam int         IDX_W       = 3;
  localparam logic [10:0] SEQ_RST    = 11'h000;
  localparam logic [10:0] SEQ_ONE    = 11'h001;
  // register byte addresses
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_EXEMPT  = 8'h04;
  localparam logic [7:0] OFS_CVS     = 8'h08;
  localparam logic [7:0] OFS_CRP     = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_SEQ     = 8'h14;
  // control fields
  localparam int         CTRL_SHARED = 0;
  localparam int         CTRL_BZERO  = 1;
  localparam int         CTRL_MASTER = 2;
  localparam int         CTRL_BPSW   = 3;
  localparam logic [3:0] CTRL_RST    = 4'h0;
  localparam logic [7:0] EXEMPT_RST  = 8'h00;
  localparam logic [15:0] CRP_RST    = 16'h0000;
  // contact verification limit, clock at 10 MHz
  localparam int         CLK_MHZ     = 10;
  localparam int         CVS_TIME_US = 1000;
  localparam int         CVS_CYC     = CVS_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {WTX_MSDU, WTX_MCDU, WTX_BEACON, WTX_SPARE} wtx_kind_t;
endpackage

// ===== hdl/wtx_seq.sv
// transmit sequence numbering, more-frames gating and beacon element control
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/1ps
module wtx_seq
  import wtx_pkg::*;
#(
  parameter logic [23:0] CVS_LIMIT = 24'(wtx_pkg::CVS_CYC)
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // register bus
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // transmit request
  input  wire logic        tx_req,
  input  wire logic [1:0]  tx_kind,
  input  wire logic [2:0]  tx_flow,
  input  wire logic        tx_ba,
  input  wire logic        tx_last_frag,
  input  wire logic        tx_retx,
  input  wire logic        tx_more,
  input  wire logic        tx_access,
  // transmit answer
  output logic             tx_done,
  output logic             tx_granted,
  output logic [10:0]      tx_seq,
  output logic             tx_retry,
  // superframe timing
  input  wire logic        sf_start,
  input  wire logic        rblk_end,
  input  wire logic        beacon_sent,
  // receive events
  input  wire logic        rx_valid,
  input  wire logic [2:0]  rx_key,
  input  wire logic        rx_retry,
  input  wire logic [10:0] rx_seq,
  input  wire logic        rx_nbr_bcn,
  input  wire logic [2:0]  rx_nbr_slot,
  input  wire logic        rx_hib,
  input  wire logic [7:0]  rx_hib_sf,
  input  wire logic        rx_assoc_req,
  input  wire logic        rx_meas_req,
  input  wire logic        incumbent_det,
  input  wire logic        rx_cvs,
  input  wire logic        chresp_sent,
  input  wire logic [7:0]  chresp_chan,
  // receive answer
  output logic             rx_dup,
  output logic             rx_deliver,
  // beacon content, transmit enable and current channel
  output logic             ie_bpoie,
  output logic [7:0]       bpo_occ,
  output logic [7:0]       bpo_fixed,
  output logic             ie_assoc_resp,
  output logic             ie_bp_switch,
  output logic             bpst_change,
  output logic             ie_meas_report,
  output logic [7:0]       ie_crp,
  output logic             tx_enable,
  output logic [7:0]       cur_chan
);
  import wtx_pkg::*;

  function automatic logic [10:0] seq_inc(input logic [10:0] s);
    seq_inc = s + SEQ_ONE;
  endfunction

  // ----------------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------------
  logic [3:0]  ctrl;
  logic [7:0]  exempt;
  logic [23:0] cvs_lim;
  logic [15:0] crp_cfg;
  logic [10:0] flow_seq [NFLOW];
  logic [10:0] common_seq;
  logic [10:0] mcdu_seq;
  logic [10:0] bcn_seq;
  logic [7:0]  rblk_blk;
  logic [7:0]  pca_blk;
  logic        setup;
  logic        wr_en;
  logic        mapped;
  logic [31:0] rd_mux;

  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pready && pwrite && !pslverr;
  assign mapped = paddr == OFS_CTRL || paddr == OFS_EXEMPT || paddr == OFS_CVS
               || paddr == OFS_CRP || paddr == OFS_STATUS || paddr == OFS_SEQ;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL:   rd_mux[3:0]  = ctrl;
      OFS_EXEMPT: rd_mux[7:0]  = exempt;
      OFS_CVS:    rd_mux[23:0] = cvs_lim;
      OFS_CRP:    rd_mux[15:0] = crp_cfg;
      OFS_STATUS: rd_mux = {8'h00, pca_blk, rblk_blk, 4'h0, ie_meas_report,
                            ie_assoc_resp, ie_bp_switch, tx_enable};
      OFS_SEQ:    rd_mux = {5'h00, bcn_seq, 5'h00, mcdu_seq};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // no wait state: answer raised in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup) begin
        prdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= CTRL_RST;
      exempt  <= EXEMPT_RST;
      cvs_lim <= CVS_LIMIT;
      crp_cfg <= CRP_RST;
    end else if (wr_en) begin
      unique case (paddr)
        OFS_CTRL:   ctrl    <= pwdata[3:0];
        OFS_EXEMPT: exempt  <= pwdata[7:0];
        OFS_CVS:    cvs_lim <= pwdata[23:0];
        OFS_CRP:    crp_cfg <= pwdata[15:0];
        default:    ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // transmit grant and numbering
  // ----------------------------------------------------------------------
  logic        is_data;
  logic        is_bcn;
  logic        go_ok;
  logic        adv;
  logic        use_flow;
  logic [10:0] next_seq;

  assign is_data  = tx_kind == WTX_MSDU || tx_kind == WTX_MCDU;
  assign is_bcn   = tx_kind == WTX_BEACON;
  // recipient gate uses the flow index as recipient slot
  assign go_ok    = tx_enable && (is_bcn || (is_data && (tx_access ?
                    !rblk_blk[tx_flow] : !pca_blk[tx_flow])));
  assign adv      = tx_req && go_ok && is_data && !tx_retx && tx_last_frag;
  assign use_flow = tx_ba || !ctrl[CTRL_SHARED];

  always_comb begin
    next_seq = SEQ_RST;
    unique case (tx_kind)
      WTX_MCDU:   next_seq = mcdu_seq;
      WTX_MSDU:   next_seq = use_flow ? flow_seq[tx_flow] : common_seq;
      WTX_BEACON: next_seq = ctrl[CTRL_BZERO] ? SEQ_RST : bcn_seq;
      default:    next_seq = SEQ_RST;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      common_seq <= SEQ_RST;
      mcdu_seq   <= SEQ_RST;
      for (int i = 0; i < NFLOW; i++) begin
        flow_seq[i] <= SEQ_RST;
      end
    end else if (adv) begin
      if (tx_kind == WTX_MCDU) begin
        mcdu_seq <= seq_inc(mcdu_seq);
      end else if (use_flow) begin
        flow_seq[tx_flow] <= seq_inc(flow_seq[tx_flow]);
      end else begin
        common_seq <= seq_inc(common_seq);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcn_seq <= SEQ_RST;
    end else if (sf_start) begin
      bcn_seq <= seq_inc(bcn_seq);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_done    <= 1'b0;
      tx_granted <= 1'b0;
      tx_seq     <= SEQ_RST;
      tx_retry   <= 1'b0;
    end else begin
      tx_done    <= tx_req;
      tx_granted <= tx_req && go_ok;
      if (tx_req) begin
        tx_seq   <= next_seq;
        tx_retry <= tx_retx;
      end
    end
  end

  // block set wins over the period-end clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rblk_blk <= 8'h00;
      pca_blk  <= 8'h00;
    end else begin
      if (rblk_end) begin
        rblk_blk <= 8'h00;
      end
      if (sf_start) begin
        pca_blk <= 8'h00;
      end
      if (tx_req && go_ok && is_data && !tx_more) begin
        if (tx_access) begin
          rblk_blk[tx_flow] <= 1'b1;
        end else if (!exempt[tx_flow]) begin
          pca_blk[tx_flow] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // receive duplicate filter
  // ----------------------------------------------------------------------
  logic [10:0] last_rx [NFLOW];
  logic [7:0]  rx_seen;
  logic        dup_now;

  assign dup_now = rx_retry && rx_seen[rx_key] && last_rx[rx_key] == rx_seq;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_seen <= 8'h00;
      for (int i = 0; i < NFLOW; i++) begin
        last_rx[i] <= SEQ_RST;
      end
    end else if (rx_valid) begin
      rx_seen[rx_key] <= 1'b1;
      last_rx[rx_key] <= rx_seq;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_dup     <= 1'b0;
      rx_deliver <= 1'b0;
    end else begin
      rx_dup     <= rx_valid && dup_now;
      rx_deliver <= rx_valid && !dup_now;
    end
  end

  // ----------------------------------------------------------------------
  // beacon slot occupancy
  // ----------------------------------------------------------------------
  logic [7:0] heard;
  logic [7:0] hib_cnt [NFLOW];
  logic [7:0] hib_on;

  always_comb begin
    for (int i = 0; i < NFLOW; i++) begin
      hib_on[i] = hib_cnt[i] != 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      heard <= 8'h00;
    end else begin
      if (sf_start) begin
        heard <= 8'h00;
      end
      if (rx_nbr_bcn) begin
        heard[rx_nbr_slot] <= 1'b1;
      end
    end
  end

  // hibernation count in superframes, per slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NFLOW; i++) begin
        hib_cnt[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < NFLOW; i++) begin
        if (rx_hib && rx_nbr_slot == 3'(i)) begin
          hib_cnt[i] <= rx_hib_sf;
        end else if (sf_start && hib_on[i]) begin
          hib_cnt[i] <= hib_cnt[i] - 8'h01;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_bpoie  <= 1'b0;
      bpo_occ   <= 8'h00;
      bpo_fixed <= 8'h00;
      ie_crp    <= 8'h00;
    end else begin
      ie_bpoie <= 1'b1;
      if (sf_start) begin
        bpo_occ   <= heard | hib_on;
        bpo_fixed <= hib_on;
        ie_crp    <= crp_cfg[7:0] | (ctrl[CTRL_MASTER] ? crp_cfg[15:8] : 8'h00);
      end
    end
  end

  // ----------------------------------------------------------------------
  // pending beacon elements
  // ----------------------------------------------------------------------
  // request arriving with the beacon still sets the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_assoc_resp  <= 1'b0;
      ie_meas_report <= 1'b0;
      ie_bp_switch   <= 1'b0;
      bpst_change    <= 1'b0;
    end else begin
      if (rx_assoc_req) begin
        ie_assoc_resp <= 1'b1;
      end else if (beacon_sent) begin
        ie_assoc_resp <= 1'b0;
      end
      if (rx_meas_req || incumbent_det) begin
        ie_meas_report <= 1'b1;
      end else if (beacon_sent) begin
        ie_meas_report <= 1'b0;
      end
      if (sf_start) begin
        ie_bp_switch <= ctrl[CTRL_BPSW];
      end
      // start time moves only after a beacon that carried the switch element
      bpst_change <= beacon_sent && ie_bp_switch;
    end
  end

  // ----------------------------------------------------------------------
  // contact verification and channel
  // ----------------------------------------------------------------------
  logic [23:0] cvs_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cvs_cnt   <= 24'h00_0000;
      tx_enable <= 1'b0;
    end else begin
      if (rx_cvs) begin
        cvs_cnt   <= 24'h00_0000;
        tx_enable <= 1'b1;
      end else if (cvs_cnt >= cvs_lim) begin
        tx_enable <= 1'b0;
      end else begin
        cvs_cnt <= cvs_cnt + 24'h00_0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_chan <= 8'h00;
    end else if (chresp_sent) begin
      cur_chan <= chresp_chan;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_last_res;
    tx_req && go_ok && is_data && tx_access && !tx_more;
  endsequence

  // repeat request three cycles on, with no block end in between
  chk_res_block: assert property (s_last_res ##1 (!rblk_end)[*2]
      ##1 tx_req && tx_access && tx_flow == $past(tx_flow, 3) |-> ##1 !tx_granted)
    else $error("frame granted after last frame in reservation");
  chk_pca_block: assert property (tx_req && go_ok && is_data && !tx_access
      && !tx_more && !exempt[tx_flow] && !sf_start |=> pca_blk[$past(tx_flow)])
    else $error("contention block not set");
  chk_seq_wrap: assert property (adv && tx_kind == WTX_MSDU && use_flow
      && flow_seq[tx_flow] == 11'h7ff |=> flow_seq[$past(tx_flow)] == SEQ_RST)
    else $error("flow counter did not wrap");
  chk_frag_hold: assert property (tx_req && is_data && !tx_last_frag
      |=> $stable(mcdu_seq) && $stable(common_seq)
      && flow_seq[$past(tx_flow)] == $past(flow_seq[tx_flow]))
    else $error("counter moved on inner fragment");
  chk_adv_one: assert property (adv && tx_kind == WTX_MSDU && !use_flow
      |=> common_seq == $past(common_seq) + SEQ_ONE)
    else $error("shared counter not advanced by one");
  chk_mcdu_sep: assert property (adv && tx_kind == WTX_MCDU |=> $stable(common_seq))
    else $error("command unit touched data counter");
  chk_bcn_zero: assert property (tx_req && is_bcn && ctrl[CTRL_BZERO]
      |=> tx_done && tx_seq == SEQ_RST)
    else $error("beacon number not zero");
  chk_dup_drop: assert property (rx_valid && dup_now |=> rx_dup && !rx_deliver)
    else $error("duplicate delivered");
  chk_retry_bit: assert property (tx_req && tx_retx |=> tx_retry && tx_done)
    else $error("retry bit missing");
  chk_cvs_stop: assert property (!rx_cvs && cvs_cnt >= cvs_lim |=> !tx_enable)
    else $error("still enabled after contact timeout");
  chk_chan_move: assert property (chresp_sent |=> cur_chan == $past(chresp_chan))
    else $error("channel not taken");
  chk_assoc_ie: assert property (rx_assoc_req |=> ie_assoc_resp)
    else $error("association response not pending");
endmodule

// ===== sim/wtx_peer.sv
// peer device model: received frames, neighbour beacons and contact signals
`timescale 1ns/1ps
module wtx_peer (
  // clock and control
  input  wire logic pclk,
  input  wire logic cvs_on,
  // received frame
  output logic        rx_valid,
  output logic [2:0]  rx_key,
  output logic        rx_retry,
  output logic [10:0] rx_seq,
  // received elements
  output logic        rx_nbr_bcn,
  output logic [2:0]  rx_nbr_slot,
  output logic        rx_hib,
  output logic [7:0]  rx_hib_sf,
  output logic        rx_assoc_req,
  output logic        rx_meas_req,
  output logic        incumbent_det,
  output logic        rx_cvs
);
  int cnt = 0;
  initial begin
    {rx_valid, rx_key, rx_retry, rx_seq, rx_cvs} = '0;
    {rx_nbr_bcn, rx_nbr_slot, rx_hib, rx_hib_sf} = '0;
    {rx_assoc_req, rx_meas_req, incumbent_det} = '0;
  end
  // contact signal well inside the timeout, only while enabled
  always @(posedge pclk) begin
    cnt <= (cnt + 1) % 8;
    rx_cvs <= cvs_on && cnt == 0;
  end
  // lines go to the inverse once released, never hold a stale value
  task automatic frame(input logic [2:0] k, input logic [10:0] s, input logic r);
    @(posedge pclk);
    {rx_valid, rx_key, rx_seq, rx_retry} <= {1'b1, k, s, r};
    @(posedge pclk);
    {rx_valid, rx_key, rx_seq, rx_retry} <= {1'b0, ~k, ~s, ~r};
  endtask
  task automatic bcn(input logic h, input logic [2:0] sl, input logic [7:0] n);
    @(posedge pclk);
    {rx_nbr_bcn, rx_hib, rx_nbr_slot, rx_hib_sf} <= {~h, h, sl, n};
    @(posedge pclk);
    {rx_nbr_bcn, rx_hib, rx_nbr_slot, rx_hib_sf} <= {2'b00, ~sl, ~n};
  endtask
  task automatic evt(input logic [2:0] c);
    @(posedge pclk);
    {rx_assoc_req, rx_meas_req, incumbent_det} <= c;
    @(posedge pclk);
    {rx_assoc_req, rx_meas_req, incumbent_det} <= 3'h0;
  endtask
endmodule

// ===== sim/testbench.sv
// self-checking bench for transmit sequencing and beacon element control
`timescale 1ns/1ps
module testbench;
  import wtx_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, tx_req = 1'b0, cvs_on = 1'b0;
  logic [1:0] tx_kind = 2'h0;
  logic [2:0] tx_flow = 3'h0, rx_key, rx_nbr_slot;
  logic tx_ba = 1'b0, tx_last_frag = 1'b0, tx_retx = 1'b0, tx_more = 1'b0, tx_access = 1'b0;
  logic sf_start = 1'b0, rblk_end = 1'b0, beacon_sent = 1'b0, chresp_sent = 1'b0;
  logic [7:0] chresp_chan = 8'h00, rx_hib_sf, bpo_occ, bpo_fixed, ie_crp, cur_chan;
  logic [10:0] tx_seq, rx_seq;
  logic tx_done, tx_granted, tx_retry, rx_valid, rx_retry, rx_nbr_bcn, rx_hib, rx_cvs;
  logic rx_assoc_req, rx_meas_req, incumbent_det, rx_dup, rx_deliver, ie_bpoie;
  logic ie_assoc_resp, ie_bp_switch, bpst_change, ie_meas_report, tx_enable;
  int n_mismatch = 0, samples_checked = 0;
  always #50 pclk = ~pclk;
  wtx_seq #(.CVS_LIMIT(24'd20)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_req(tx_req), .tx_kind(tx_kind),
    .tx_flow(tx_flow), .tx_ba(tx_ba), .tx_last_frag(tx_last_frag), .tx_retx(tx_retx),
    .tx_more(tx_more), .tx_access(tx_access), .tx_done(tx_done), .tx_granted(tx_granted),
    .tx_seq(tx_seq), .tx_retry(tx_retry), .sf_start(sf_start), .rblk_end(rblk_end),
    .beacon_sent(beacon_sent), .rx_valid(rx_valid), .rx_key(rx_key), .rx_retry(rx_retry),
    .rx_seq(rx_seq), .rx_nbr_bcn(rx_nbr_bcn), .rx_nbr_slot(rx_nbr_slot), .rx_hib(rx_hib),
    .rx_hib_sf(rx_hib_sf), .rx_assoc_req(rx_assoc_req), .rx_meas_req(rx_meas_req),
    .incumbent_det(incumbent_det), .rx_cvs(rx_cvs), .chresp_sent(chresp_sent),
    .chresp_chan(chresp_chan), .rx_dup(rx_dup), .rx_deliver(rx_deliver),
    .ie_bpoie(ie_bpoie), .bpo_occ(bpo_occ), .bpo_fixed(bpo_fixed),
    .ie_assoc_resp(ie_assoc_resp), .ie_bp_switch(ie_bp_switch), .bpst_change(bpst_change),
    .ie_meas_report(ie_meas_report), .ie_crp(ie_crp), .tx_enable(tx_enable),
    .cur_chan(cur_chan));
  wtx_peer peer (.pclk(pclk), .cvs_on(cvs_on), .rx_valid(rx_valid), .rx_key(rx_key),
    .rx_retry(rx_retry), .rx_seq(rx_seq), .rx_nbr_bcn(rx_nbr_bcn),
    .rx_nbr_slot(rx_nbr_slot), .rx_hib(rx_hib), .rx_hib_sf(rx_hib_sf),
    .rx_assoc_req(rx_assoc_req), .rx_meas_req(rx_meas_req),
    .incumbent_det(incumbent_det), .rx_cvs(rx_cvs));
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: a slave that never answers is caught by the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    chk(pready, 1, "ready");
    chk(pslverr, e, "slave error");
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(rdat, exp, "register read");
  endtask
  // o packs block-ack, last fragment, retransmit, more frames, access method
  task automatic tx(input logic [1:0] k, input logic [2:0] f, input logic [4:0] o,
                    input logic g, input int s);
    @(posedge pclk);
    {tx_req, tx_kind, tx_flow} <= {1'b1, k, f};
    {tx_ba, tx_last_frag, tx_retx, tx_more, tx_access} <= o;
    @(posedge pclk);
    tx_req <= 1'b0;
    @(posedge pclk);
    chk({tx_done, tx_granted}, {1'b1, g}, "grant");
    if (g && s >= 0) chk(tx_seq, s[10:0], "sequence");
    if (g) chk(tx_retry, o[2], "retry bit");
  endtask
  // c: 0 superframe start, 1 block end, 2 beacon sent, 3 channel response
  task automatic own(input int c, input logic [7:0] ch);
    @(posedge pclk);
    {sf_start, rblk_end, beacon_sent, chresp_sent} <= 4'(8 >> c);
    chresp_chan <= ch;
    @(posedge pclk);
    {sf_start, rblk_end, beacon_sent, chresp_sent} <= 4'h0;
    chresp_chan <= ~ch;
  endtask
  task automatic rx(input logic [2:0] k, input logic [10:0] s, input logic r,
                    input logic [1:0] e);
    peer.frame(k, s, r);
    @(posedge pclk);
    chk({rx_dup, rx_deliver}, e, "receive verdict");
  endtask
  task automatic done(input string s);
    $display("test %s finished, mismatches so far %0d", s, n_mismatch);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    // element flag rises at the first edge after release, seen one edge later
    repeat (2) @(posedge pclk);
    chk(ie_bpoie, 1, "occupancy element");
    rd(OFS_SEQ, 0);
    rd(OFS_CTRL, 32'(CTRL_RST));
    rd(OFS_EXEMPT, 32'(EXEMPT_RST));
    rd(OFS_CRP, 32'(CRP_RST));
    apb(1'b1, OFS_STATUS, '1, 1'b0);
    rd(OFS_STATUS, 0);
    apb(1'b0, 8'h18, 32'h0, 1'b1);
    chk(rdat, 0, "unmapped read");
    tx(0, 2, 5'b11010, 0, -1);
    cvs_on <= 1'b1;
    repeat (12) @(posedge pclk);
    chk(tx_enable, 1, "enabled by contact");
    done("reset");
  endtask
  task automatic t_count;
    tx(0, 2, 5'b11010, 1, 0);
    tx(0, 2, 5'b11010, 1, 1);
    tx(0, 3, 5'b11010, 1, 0);
    tx(1, 2, 5'b01010, 1, 0);
    rd(OFS_SEQ, 1);
    tx(0, 4, 5'b10010, 1, 0);
    tx(0, 4, 5'b10010, 1, 0);
    tx(0, 4, 5'b11010, 1, 0);
    tx(0, 4, 5'b11010, 1, 1);
    tx(0, 4, 5'b11110, 1, 2);
    tx(0, 4, 5'b11010, 1, 2);
    apb(1'b1, OFS_CTRL, 32'h1, 1'b0);
    tx(0, 5, 5'b01010, 1, 0);
    tx(0, 6, 5'b01010, 1, 1);
    tx(0, 2, 5'b11010, 1, 2);
    apb(1'b1, OFS_CTRL, 32'h0, 1'b0);
    tx(0, 5, 5'b01010, 1, 0);
    tx(3, 0, 5'b11010, 0, -1);
    done("count");
  endtask
  task automatic t_beacon;
    tx(2, 0, 5'b01010, 1, 0);
    own(0, 8'h00);
    tx(2, 0, 5'b01010, 1, 1);
    rd(OFS_SEQ, 32'h0001_0001);
    apb(1'b1, OFS_CTRL, 32'h2, 1'b0);
    tx(2, 0, 5'b01010, 1, 0);
    apb(1'b1, OFS_CTRL, 32'h0, 1'b0);
    done("beacon");
  endtask
  task automatic t_more;
    tx(0, 1, 5'b11001, 1, -1);
    tx(0, 1, 5'b11011, 0, -1);
    tx(0, 0, 5'b11011, 1, -1);
    rd(OFS_STATUS, 32'h0000_0201);
    own(1, 8'h00);
    tx(0, 1, 5'b11011, 1, -1);
    tx(0, 1, 5'b11000, 1, -1);
    tx(0, 1, 5'b11010, 0, -1);
    rd(OFS_STATUS, 32'h0002_0001);
    own(0, 8'h00);
    tx(0, 1, 5'b11010, 1, -1);
    apb(1'b1, OFS_EXEMPT, 32'h2, 1'b0);
    tx(0, 1, 5'b11000, 1, -1);
    tx(0, 1, 5'b11010, 1, -1);
    apb(1'b1, OFS_EXEMPT, 32'h0, 1'b0);
    done("more frames");
  endtask
  task automatic t_rx;
    rx(3, 11'h123, 1'b0, 2'b01);
    rx(3, 11'h123, 1'b1, 2'b10);
    rx(3, 11'h124, 1'b1, 2'b01);
    rx(4, 11'h124, 1'b1, 2'b01);
    done("receive");
  endtask
  task automatic t_ie;
    peer.evt(3'b100);
    @(posedge pclk);
    chk(ie_assoc_resp, 1, "association response");
    own(2, 8'h00);
    @(posedge pclk);
    chk({ie_assoc_resp, bpst_change}, 0, "cleared by beacon");
    peer.evt(3'b010);
    @(posedge pclk);
    chk(ie_meas_report, 1, "measurement report");
    own(2, 8'h00);
    peer.evt(3'b001);
    @(posedge pclk);
    chk(ie_meas_report, 1, "incumbent report");
    own(3, 8'h2a);
    @(posedge pclk);
    chk(cur_chan, 8'h2a, "channel moved");
    apb(1'b1, OFS_CTRL, 32'h8, 1'b0);
    own(0, 8'h00);
    @(posedge pclk);
    chk(ie_bp_switch, 1, "switch announced");
    own(2, 8'h00);
    @(posedge pclk);
    chk(bpst_change, 1, "start time change");
    apb(1'b1, OFS_CTRL, 32'h4, 1'b0);
    apb(1'b1, OFS_CRP, 32'h3c05, 1'b0);
    peer.bcn(1'b0, 3'h5, 8'h00);
    peer.bcn(1'b1, 3'h3, 8'h02);
    @(posedge pclk);
    chk({bpo_occ, bpo_fixed}, 0, "held until superframe start");
    own(0, 8'h00);
    @(posedge pclk);
    chk({bpo_occ, bpo_fixed, ie_crp}, 24'h28083d, "beacon elements");
    apb(1'b1, OFS_CTRL, 32'h0, 1'b0);
    repeat (4) own(0, 8'h00);
    @(posedge pclk);
    chk({bpo_occ, bpo_fixed, ie_crp}, 24'h000005, "elements aged");
    chk(ie_bp_switch, 0, "switch withdrawn");
    done("elements");
  endtask
  task automatic t_wrap;
    for (int i = 0; i < 2049; i++) tx(0, 7, 5'b11010, 1, i % 2048);
    done("wrap");
  endtask
  task automatic t_cvs;
    cvs_on <= 1'b0;
    repeat (30) @(posedge pclk);
    chk(tx_enable, 0, "contact timeout");
    tx(1, 0, 5'b01010, 0, -1);
    rd(OFS_STATUS, 0);
    done("contact");
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_count;
    t_beacon;
    t_more;
    t_rx;
    t_ie;
    t_wrap;
    t_cvs;
    complete_run;
  end
  // tests take about 6400 cycles
  initial begin
    repeat (14000) @(posedge pclk);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run;
  end
endmodule
